// file: ctu_pkg.sv
// constants shared by the charge time unit control logic
package ctu_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] CTU_IDX_ICON = 12'hfb1;
    localparam logic [11:0] CTU_IDX_CONL = 12'hfb2;
    localparam logic [11:0] CTU_IDX_CONH = 12'hfb3;
    localparam logic [11:0] CTU_IDX_IRQ_STAT = 12'hfb4;
    localparam logic [11:0] CTU_IDX_IRQ_MASK = 12'hfb5;
    localparam int CTU_ADDR_W = 14;

    // ------------------------------------------------------------
    // module_control_high fields
    // ------------------------------------------------------------
    localparam int CTU_H_UNIT_EN = 7;
    localparam int CTU_H_RSVD = 6;
    localparam int CTU_H_IDLE_STOP = 5;
    localparam int CTU_H_DLY_EN = 4;
    localparam int CTU_H_EDGE_GATE = 3;
    localparam int CTU_H_ORDER = 2;
    localparam int CTU_H_DISCH = 1;
    localparam int CTU_H_TRIG = 0;

    // ------------------------------------------------------------
    // edge_control_low fields
    // ------------------------------------------------------------
    localparam int CTU_L_E2_POL = 7;
    localparam int CTU_L_E2_SRC = 5;
    localparam int CTU_L_E1_POL = 4;
    localparam int CTU_L_E1_SRC = 2;
    localparam int CTU_L_E2_STAT = 1;
    localparam int CTU_L_E1_STAT = 0;

    // ------------------------------------------------------------
    // current_source_control fields
    // ------------------------------------------------------------
    localparam int CTU_I_TRIM = 2;
    localparam int CTU_I_RANGE = 0;
    localparam logic [1:0] CTU_RANGE_OFF = 2'h0;

    // edge source selector codes
    localparam logic [1:0] CTU_SRC_PIN1 = 2'h3;
    localparam logic [1:0] CTU_SRC_PIN2 = 2'h2;
    localparam logic [1:0] CTU_SRC_CMP = 2'h1;
    localparam logic [1:0] CTU_SRC_TMR = 2'h0;

    // interrupt status bits
    localparam int CTU_IRQ_E1 = 0;
    localparam int CTU_IRQ_E2 = 1;
    localparam int CTU_IRQ_TRIP = 2;
    localparam int CTU_IRQ_W = 3;

    // reset values
    localparam logic [7:0] CTU_RST_REG = 8'h00;
    localparam logic [CTU_IRQ_W-1:0] CTU_RST_IRQ = 3'h0;
endpackage

// file: ctu_top.sv
// charge time unit control: registers, edge logic, source gating, delay pulse
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps

// Summary of operation
// - unit enable bit runs or stops unit
// - idle stop bit cuts source in idle
// - delay mode pulses output at comparator trip
// - edge gate bit passes or blocks edges
// - ordering: edge two waits for edge one
// - discharge bit grounds current source output
// - trigger bit enables special event trigger
// - polarity bit picks rising or falling edge
// - two-bit selector picks each edge source
// - status bits set by events, software writable
// - six-bit signed trim passed to source
// - two-bit range, zero disables source
// - sleep always disables current source
// - reset clears all unit registers
// - unused high control bit reads zero
module ctu_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [ctu_pkg::CTU_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_edge_input_pin_one,
    input wire logic i_edge_input_pin_two,
    input wire logic i_enhanced_compare_output,
    input wire logic i_timer_one_event,
    input wire logic i_comparator_trip,
    input wire logic i_idle_mode,
    input wire logic i_sleep_mode,
    output logic o_source_enable,
    output logic o_source_discharge,
    output logic [1:0] o_current_range,
    output logic [5:0] o_current_trim,
    output logic o_delay_pulse_out,
    output logic o_special_trigger,
    output logic o_irq
);
    import ctu_pkg::*;

    // ------------------------------------------------------------
    // synchronisers for pins and the analog comparator
    // ------------------------------------------------------------
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] nxt_sync1;
    logic [2:0] nxt_sync2;

    always_comb begin
        nxt_sync1 = {i_comparator_trip, i_edge_input_pin_two, i_edge_input_pin_one};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic req;
    logic wr_go;
    logic lane0;
    logic [11:0] idx;
    logic [7:0] wbyte;

    logic [7:0] icon_ff;
    logic [7:0] conh_ff;
    logic [7:2] conl_ff;
    logic [1:0] stat_ff;
    logic [CTU_IRQ_W-1:0] irq_stat_ff;
    logic [CTU_IRQ_W-1:0] irq_mask_ff;

    assign req = i_avs_read | i_avs_write;
    assign idx = i_avs_address[CTU_ADDR_W-1:2];
    assign wbyte = i_avs_writedata[7:0];
    assign lane0 = i_avs_byteenable[0];
    // write lands only at the edge where waitrequest is seen low
    assign wr_go = i_avs_write & ack_ff & lane0;
    assign o_avs_waitrequest = req & ~ack_ff;
    assign o_avs_readdata = rdata_ff;

    always_comb begin
        nxt_ack = req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (i_avs_read && !ack_ff) begin
            nxt_rdata = 32'h0;
            unique case (idx)
                CTU_IDX_ICON: nxt_rdata[7:0] = icon_ff;
                CTU_IDX_CONL: nxt_rdata[7:0] = {conl_ff, stat_ff};
                CTU_IDX_CONH: begin
                    nxt_rdata[7:0] = conh_ff;
                    nxt_rdata[CTU_H_RSVD] = 1'b0;
                end
                CTU_IDX_IRQ_STAT: nxt_rdata[CTU_IRQ_W-1:0] = irq_stat_ff;
                CTU_IDX_IRQ_MASK: nxt_rdata[CTU_IRQ_W-1:0] = irq_mask_ff;
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // edge sources, polarity and detection
    // ------------------------------------------------------------
    logic [1:0] lvl;
    logic [1:0] lvl_prev_ff;
    logic [1:0] nxt_lvl_prev;
    logic [1:0] hit;
    logic [1:0] pol;
    logic [1:0] sel [2];
    logic [3:0] srcs;
    logic gate_open;
    logic [1:0] ev;

    assign srcs = {sync2_ff[0], sync2_ff[1], i_enhanced_compare_output, i_timer_one_event};
    assign pol = {conl_ff[CTU_L_E2_POL], conl_ff[CTU_L_E1_POL]};
    assign sel[0] = conl_ff[CTU_L_E1_SRC+1:CTU_L_E1_SRC];
    assign sel[1] = conl_ff[CTU_L_E2_SRC+1:CTU_L_E2_SRC];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            assign lvl[g] = srcs[sel[g]];
            // polarity decides which transition counts
            assign hit[g] = pol[g] ? (lvl[g] & ~lvl_prev_ff[g]) : (~lvl[g] & lvl_prev_ff[g]);
        end
    endgenerate

    // disabled unit or closed gate sees no edges at all
    assign gate_open = conh_ff[CTU_H_UNIT_EN] & conh_ff[CTU_H_EDGE_GATE];
    assign ev[0] = gate_open & hit[0];
    // ordering holds edge two back until edge one has happened
    assign ev[1] = gate_open & hit[1] & (~conh_ff[CTU_H_ORDER] | stat_ff[0]);

    always_comb begin
        nxt_lvl_prev = lvl;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            lvl_prev_ff <= 2'h0;
        end else begin
            lvl_prev_ff <= nxt_lvl_prev;
        end
    end

    // ------------------------------------------------------------
    // control registers and edge status
    // ------------------------------------------------------------
    logic [7:0] nxt_icon;
    logic [7:0] nxt_conh;
    logic [7:2] nxt_conl;
    logic [1:0] nxt_stat;
    logic [CTU_IRQ_W-1:0] nxt_irq_stat;
    logic [CTU_IRQ_W-1:0] nxt_irq_mask;
    logic trip_prev_ff;
    logic trip_rise;
    logic trip_ev;
    logic [CTU_IRQ_W-1:0] irq_ev;

    assign trip_rise = sync2_ff[2] & ~trip_prev_ff;
    assign trip_ev = trip_rise & conh_ff[CTU_H_UNIT_EN] & conh_ff[CTU_H_DLY_EN] & stat_ff[0];
    assign irq_ev = {trip_ev, ev[1], ev[0]};

    always_comb begin
        nxt_icon = icon_ff;
        nxt_conh = conh_ff;
        nxt_conl = conl_ff;
        nxt_stat = stat_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr_go) begin
            unique case (idx)
                CTU_IDX_ICON: nxt_icon = wbyte;
                CTU_IDX_CONL: begin
                    nxt_conl = wbyte[7:2];
                    nxt_stat = wbyte[1:0];
                end
                CTU_IDX_CONH: nxt_conh = wbyte & ~(8'h01 << CTU_H_RSVD);
                CTU_IDX_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~wbyte[CTU_IRQ_W-1:0];
                CTU_IDX_IRQ_MASK: nxt_irq_mask = wbyte[CTU_IRQ_W-1:0];
                default: nxt_icon = icon_ff;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        nxt_stat = nxt_stat | ev;
        nxt_irq_stat = nxt_irq_stat | irq_ev;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            icon_ff <= CTU_RST_REG;
            conh_ff <= CTU_RST_REG;
            conl_ff <= CTU_RST_REG[7:2];
            stat_ff <= CTU_RST_REG[1:0];
            irq_stat_ff <= CTU_RST_IRQ;
            irq_mask_ff <= CTU_RST_IRQ;
            trip_prev_ff <= 1'b0;
        end else begin
            icon_ff <= nxt_icon;
            conh_ff <= nxt_conh;
            conl_ff <= nxt_conl;
            stat_ff <= nxt_stat;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            trip_prev_ff <= sync2_ff[2];
        end
    end

    // ------------------------------------------------------------
    // analog controls and pulse outputs
    // ------------------------------------------------------------
    logic src_en_ff;
    logic disch_ff;
    logic pulse_ff;
    logic trig_ff;
    logic irq_ff;
    logic [1:0] range_ff;
    logic [5:0] trim_ff;
    logic nxt_src_en;
    logic nxt_disch;
    logic nxt_pulse;
    logic nxt_trig;
    logic nxt_irq;
    logic low_power_stop;

    // sleep cuts the source regardless; idle only with idle stop set
    assign low_power_stop = i_sleep_mode | (i_idle_mode & conh_ff[CTU_H_IDLE_STOP]);

    always_comb begin
        nxt_src_en = conh_ff[CTU_H_UNIT_EN]
            & (icon_ff[CTU_I_RANGE+1:CTU_I_RANGE] != CTU_RANGE_OFF)
            & stat_ff[0] & ~stat_ff[1]
            & ~conh_ff[CTU_H_DISCH]
            & ~low_power_stop;
        nxt_disch = conh_ff[CTU_H_DISCH];
        nxt_pulse = trip_ev;
        // trigger fires when the second edge closes a measurement
        nxt_trig = conh_ff[CTU_H_TRIG] & ev[1];
        nxt_irq = |(irq_stat_ff & irq_mask_ff);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            src_en_ff <= 1'b0;
            disch_ff <= 1'b0;
            pulse_ff <= 1'b0;
            trig_ff <= 1'b0;
            irq_ff <= 1'b0;
            range_ff <= 2'h0;
            trim_ff <= 6'h0;
        end else begin
            src_en_ff <= nxt_src_en;
            disch_ff <= nxt_disch;
            pulse_ff <= nxt_pulse;
            trig_ff <= nxt_trig;
            irq_ff <= nxt_irq;
            range_ff <= icon_ff[CTU_I_RANGE+1:CTU_I_RANGE];
            trim_ff <= icon_ff[CTU_I_TRIM+5:CTU_I_TRIM];
        end
    end

    assign o_source_enable = src_en_ff;
    assign o_source_discharge = disch_ff;
    assign o_current_range = range_ff;
    assign o_current_trim = trim_ff;
    assign o_delay_pulse_out = pulse_ff;
    assign o_special_trigger = trig_ff;
    assign o_irq = irq_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_unit_off;
        !conh_ff[CTU_H_UNIT_EN] |=> !o_source_enable;
    endproperty
    a_unit_off: assert property (p_unit_off) else $error("source on while unit off");

    property p_idle_stop;
        (i_idle_mode && conh_ff[CTU_H_IDLE_STOP]) |=> !o_source_enable;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("source on in idle stop");

    property p_delay_pulse;
        (trip_rise && conh_ff[CTU_H_UNIT_EN] && conh_ff[CTU_H_DLY_EN] && stat_ff[0])
            |=> o_delay_pulse_out ##1 !o_delay_pulse_out;
    endproperty
    a_delay_pulse: assert property (p_delay_pulse) else $error("delay pulse missing");

    property p_no_pulse;
        !conh_ff[CTU_H_DLY_EN] |=> !o_delay_pulse_out;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("pulse without delay mode");

    property p_gate_closed;
        (!conh_ff[CTU_H_EDGE_GATE] && !wr_go) |=> $stable(stat_ff);
    endproperty
    a_gate_closed: assert property (p_gate_closed) else $error("edge passed closed gate");

    property p_order;
        (conh_ff[CTU_H_ORDER] && !stat_ff[0] && !stat_ff[1] && !wr_go) |=> !stat_ff[1];
    endproperty
    a_order: assert property (p_order) else $error("edge two before edge one");

    property p_discharge;
        conh_ff[CTU_H_DISCH] |=> (o_source_discharge && !o_source_enable);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge not applied");

    property p_trig_off;
        !conh_ff[CTU_H_TRIG] |=> !o_special_trigger;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");

    property p_edge_set;
        ev[0] |=> stat_ff[0];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge one status not set");

    property p_sleep;
        i_sleep_mode |=> !o_source_enable;
    endproperty
    a_sleep: assert property (p_sleep) else $error("source on in sleep");

    property p_rsvd;
        (i_avs_read && !o_avs_waitrequest && idx == CTU_IDX_CONH) |-> !o_avs_readdata[CTU_H_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

    property p_charge_window;
        o_source_enable |-> $past(stat_ff[0]) && !$past(stat_ff[1]);
    endproperty
    a_charge_window: assert property (p_charge_window) else $error("charge outside window");

    property p_range_off;
        (icon_ff[1:0] == CTU_RANGE_OFF) |=> !o_source_enable;
    endproperty
    a_range_off: assert property (p_range_off) else $error("source on with range off");

    property p_bus_answer;
        (req && o_avs_waitrequest) |=> !o_avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_cov_measure;
        stat_ff == 2'h1 ##[1:1000] stat_ff == 2'h3;
    endproperty
    c_measure: cover property (p_cov_measure);

    property p_cov_pulse;
        o_delay_pulse_out;
    endproperty
    c_pulse: cover property (p_cov_pulse);

    property p_cov_irq;
        $rose(o_irq);
    endproperty
    c_irq: cover property (p_cov_irq);
endmodule

// file: ctu_far_model.sv
// far-side model: capacitor charged by the current source, seen by the comparator
`timescale 1ns/1ps
module ctu_far_model #(
    parameter int TRIP_LEVEL = 400
) (
    input wire logic i_sys_clk,
    input wire logic i_source_enable,
    input wire logic i_source_discharge,
    input wire logic [1:0] i_current_range,
    output logic o_comparator_trip
);
    int charge_ff = 0;
    int nxt_charge;

    // step grows with range, so one model trips slowly or promptly
    always_comb begin
        nxt_charge = charge_ff;
        if (i_source_discharge) begin
            nxt_charge = 0;
        end else if (i_source_enable) begin
            case (i_current_range)
                2'h3: nxt_charge = charge_ff + 100;
                2'h2: nxt_charge = charge_ff + 10;
                default: nxt_charge = charge_ff + 1;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        charge_ff <= nxt_charge;
    end

    assign o_comparator_trip = (charge_ff >= TRIP_LEVEL);
endmodule

// file: tb_ctu_top.sv
// testbench for the charge time unit control block
`timescale 1ns/1ps
module tb_ctu_top;
    import ctu_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [CTU_ADDR_W-1:0] i_avs_address = 14'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic i_edge_input_pin_one = 1'b0;
    logic i_edge_input_pin_two = 1'b0;
    logic i_enhanced_compare_output = 1'b0;
    logic i_timer_one_event = 1'b0;
    logic i_idle_mode = 1'b0;
    logic i_sleep_mode = 1'b0;
    logic i_comparator_trip;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_source_enable, o_source_discharge, o_delay_pulse_out, o_special_trigger, o_irq;
    logic [1:0] o_current_range;
    logic [5:0] o_current_trim;
    logic [31:0] q;
    logic [7:0] conl;
    logic [7:0] icon_tab [4] = '{8'h7f, 8'h02, 8'h85, 8'h84};
    int n_fail = 0;
    int samples_checked = 0;
    int n_dly = 0;
    int n_trig = 0;
    int cyc_cnt = 0;
    int base;
    int n_wait;

    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    ctu_top ctu_top_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_edge_input_pin_one(i_edge_input_pin_one),
        .i_edge_input_pin_two(i_edge_input_pin_two), .i_enhanced_compare_output(i_enhanced_compare_output),
        .i_timer_one_event(i_timer_one_event), .i_comparator_trip(i_comparator_trip),
        .i_idle_mode(i_idle_mode), .i_sleep_mode(i_sleep_mode), .o_source_enable(o_source_enable),
        .o_source_discharge(o_source_discharge), .o_current_range(o_current_range),
        .o_current_trim(o_current_trim), .o_delay_pulse_out(o_delay_pulse_out),
        .o_special_trigger(o_special_trigger), .o_irq(o_irq));

    ctu_far_model ctu_far_model_inst (.i_sys_clk(i_sys_clk), .i_source_enable(o_source_enable),
        .i_source_discharge(o_source_discharge), .i_current_range(o_current_range),
        .o_comparator_trip(i_comparator_trip));

    // ------------------------------------------------------------
    // reporting and bus access
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until a rising edge sees waitrequest low; readdata taken at that edge
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        i_avs_address <= {idx, 2'h0};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= {24'h0, d};
        i_avs_byteenable <= be;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 40);
        q = o_avs_readdata;
        if (n >= 40)
            chk("bus_wait", 32'h0, 32'h1);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        // one idle edge so the next request never re-raises a strobe in this time step
        @(posedge i_sys_clk);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 4'h1);
    endtask

    task automatic rd(input string name, input logic [11:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, 4'h0);
        chk(name, {24'h0, exp}, q);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    task automatic drv(input logic [1:0] code, input logic lvl);
        case (code)
            CTU_SRC_PIN1: i_edge_input_pin_one <= lvl;
            CTU_SRC_PIN2: i_edge_input_pin_two <= lvl;
            CTU_SRC_CMP: i_enhanced_compare_output <= lvl;
            default: i_timer_one_event <= lvl;
        endcase
    endtask

    task automatic do_reset();
        i_rst_n <= 1'b0;
        wait_n(6);
        i_rst_n <= 1'b1;
        wait_n(1);
    endtask

    task automatic check_clear();
        chk("src_en_rst", 32'h0, 32'(o_source_enable));
        chk("irq_rst", 32'h0, 32'(o_irq));
        for (int k = 0; k < 5; k++) begin
            rd("reg_rst", CTU_IDX_ICON + 12'(k), 8'h00);
        end
    endtask

    // ------------------------------------------------------------
    // pulse monitors and hang guard
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (o_delay_pulse_out === 1'b1)
            n_dly <= n_dly + 1;
        if (o_special_trigger === 1'b1)
            n_trig <= n_trig + 1;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            chk("run_time", 32'h0, 32'h1);
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        check_clear();
        rd("unmapped", 12'hfb0, 8'h00);
        wr(12'hfb6, 8'hff);
        rd("unmapped_wr", 12'hfb6, 8'h00);
        xfer(1'b1, CTU_IDX_ICON, 8'hff, 4'h0);
        rd("lane_off", CTU_IDX_ICON, 8'h00);
        wr(CTU_IDX_CONH, 8'hff);
        rd("conh_bit6", CTU_IDX_CONH, 8'hbf);
        wr(CTU_IDX_CONH, 8'h00);
        foreach (icon_tab[k]) begin
            wr(CTU_IDX_ICON, icon_tab[k]);
            rd("icon", CTU_IDX_ICON, icon_tab[k]);
            wait_n(2);
            chk("trim", 32'(icon_tab[k][7:2]), 32'(o_current_trim));
            chk("range", 32'(icon_tab[k][1:0]), 32'(o_current_range));
        end
        // each source, both polarities: taken, wrong direction, gated off
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                conl = {3'h0, p[0], c[1:0], 2'h0};
                // ordering keeps the timer's edge two from setting status alongside edge one
                wr(CTU_IDX_CONH, 8'h8c);
                drv(c[1:0], !p[0]);
                wait_n(4);
                wr(CTU_IDX_CONL, conl);
                drv(c[1:0], p[0]);
                wait_n(6);
                rd("e1_taken", CTU_IDX_CONL, conl | 8'h01);
                wr(CTU_IDX_CONL, conl);
                drv(c[1:0], !p[0]);
                wait_n(6);
                rd("e1_wrong_dir", CTU_IDX_CONL, conl);
                wr(CTU_IDX_CONH, 8'h80);
                drv(c[1:0], p[0]);
                wait_n(6);
                rd("e1_gated", CTU_IDX_CONL, conl);
                drv(c[1:0], 1'b0);
            end
        end
        // edge two before edge one, with and without ordering
        for (int k = 0; k < 2; k++) begin
            base = n_trig;
            wr(CTU_IDX_CONH, (k == 0) ? 8'h8d : 8'h88);
            wr(CTU_IDX_CONL, 8'hdc);
            i_edge_input_pin_two <= 1'b1;
            wait_n(6);
            rd("e2_first", CTU_IDX_CONL, (k == 0) ? 8'hdc : 8'hde);
            i_edge_input_pin_one <= 1'b1;
            i_edge_input_pin_two <= 1'b0;
            wait_n(6);
            i_edge_input_pin_two <= 1'b1;
            wait_n(6);
            rd("e1_e2", CTU_IDX_CONL, 8'hdf);
            chk("trig_pulses", 32'(k == 0), 32'(n_trig - base));
            i_edge_input_pin_one <= 1'b0;
            i_edge_input_pin_two <= 1'b0;
            wait_n(4);
        end
        rd("irq_edges", CTU_IDX_IRQ_STAT, 8'h03);
        // charging window, idle, sleep, discharge, unit enable
        wr(CTU_IDX_ICON, 8'h05);
        wr(CTU_IDX_CONH, 8'h80);
        wr(CTU_IDX_CONL, 8'h01);
        wait_n(3);
        chk("chg_on", 32'h1, 32'(o_source_enable));
        i_idle_mode <= 1'b1;
        wait_n(3);
        chk("chg_idle", 32'h1, 32'(o_source_enable));
        wr(CTU_IDX_CONH, 8'ha0);
        wait_n(3);
        chk("chg_idle_stop", 32'h0, 32'(o_source_enable));
        i_idle_mode <= 1'b0;
        wait_n(3);
        chk("chg_idle_left", 32'h1, 32'(o_source_enable));
        i_sleep_mode <= 1'b1;
        wait_n(3);
        chk("chg_sleep", 32'h0, 32'(o_source_enable));
        i_sleep_mode <= 1'b0;
        wr(CTU_IDX_CONH, 8'h82);
        wait_n(3);
        chk("discharge", 32'h1, 32'(o_source_discharge));
        chk("chg_disch", 32'h0, 32'(o_source_enable));
        wr(CTU_IDX_CONH, 8'h80);
        wr(CTU_IDX_CONL, 8'h03);
        wait_n(3);
        chk("chg_after_e2", 32'h0, 32'(o_source_enable));
        wr(CTU_IDX_CONL, 8'h01);
        wr(CTU_IDX_CONH, 8'h00);
        wait_n(3);
        chk("chg_unit_off", 32'h0, 32'(o_source_enable));
        // delay pulse, slow then prompt source; trip interrupt unmasked then masked
        for (int k = 0; k < 2; k++) begin
            base = n_dly;
            wr(CTU_IDX_CONL, 8'h00);
            wr(CTU_IDX_IRQ_STAT, 8'h07);
            wr(CTU_IDX_IRQ_MASK, (k == 0) ? 8'h04 : 8'h00);
            wr(CTU_IDX_ICON, (k == 0) ? 8'h01 : 8'h03);
            wr(CTU_IDX_CONH, 8'h82);
            wr(CTU_IDX_CONH, 8'h80);
            wr(CTU_IDX_CONH, 8'h90);
            wr(CTU_IDX_CONL, 8'h01);
            n_wait = 0;
            while (n_dly == base && n_wait < 1000) begin
                wait_n(1);
                n_wait++;
            end
            wait_n(3);
            chk("dly_pulses", 32'h1, 32'(n_dly - base));
            chk("irq_level", 32'(k == 0), 32'(o_irq));
            xfer(1'b0, CTU_IDX_IRQ_STAT, 8'h00, 4'h0);
            chk("irq_trip", 32'h4, q & 32'h4);
            wr(CTU_IDX_IRQ_STAT, 8'h07);
            wait_n(2);
            chk("irq_clear", 32'h0, 32'(o_irq));
        end
        // reset while charging
        wr(CTU_IDX_ICON, 8'h05);
        wr(CTU_IDX_CONH, 8'h80);
        wr(CTU_IDX_CONL, 8'h01);
        do_reset();
        check_clear();
        end_sim();
    end
endmodule
